// ===== pkg/ortm_pkg.sv
// Package for the over-range detector and sample-marker block.
// Assumes one sample clock domain; all constants used by the core live here.
package ortm_pkg;

	// ==========================================
	// Widths
	localparam int SAMPLE_W    = 9;
	localparam int MAG_W       = 8;
	localparam int LINK_W      = 12;
	localparam int HOLD_SEL_W  = 3;
	localparam int TRIG_SEL_W  = 2;
	localparam int LMODE_W     = 4;
	localparam int HOLD_CNT_W  = 11;
	localparam int NUM_CH      = 4;

	// ==========================================
	// Constants
	localparam logic [HOLD_SEL_W-1:0] HOLD_SEL_MIN      = 3'h0; // 8 cycles
	localparam logic [HOLD_CNT_W-1:0] HOLD_BASE_CYCLES  = 11'h008;
	localparam logic [TRIG_SEL_W-1:0] TRIG_SEL_REPEAT   = 2'h3;
	localparam logic [LMODE_W-1:0]    LINK_MODE_0       = 4'h0;
	localparam int                    LINK_MODE0_WIDTH  = 12;
	localparam int                    MARKER_BIT_POS    = 0;
	localparam int                    SYNC_STAGES       = 3;
	localparam int                    SAMPLE_LATENCY    = 2;
	localparam logic [MAG_W-1:0]      THRESHOLD_RESET   = 8'he4;
	localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_RESET    = 11'h000;

	// Hold length from select code: 8 << sel
	function automatic logic [HOLD_CNT_W-1:0] ortm_hold_len(input logic [HOLD_SEL_W-1:0] sel);
		ortm_hold_len = HOLD_BASE_CYCLES << sel;
	endfunction

	// 8-bit magnitude of the sample; only -256 overflows, so it saturates to 255
	function automatic logic [MAG_W-1:0] ortm_mag(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] a;
		a = s;
		if (s[SAMPLE_W-1]) begin
			a = (~s) + 9'h001;
		end
		if (a[SAMPLE_W-1]) begin
			ortm_mag = 8'hff;
		end else begin
			ortm_mag = a[MAG_W-1:0];
		end
	endfunction

endpackage

// ===== core/ortm_hold_chan.sv
// One channel of over-range detection with retriggerable hold counter.
// Assumes sample arrives registered on core_clk once per cycle.
`timescale 1ns/1ps
module ortm_hold_chan
	import ortm_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  detectEnable,
	input  wire logic [SAMPLE_W-1:0]   sample,
	input  wire logic [MAG_W-1:0]      threshold,
	input  wire logic [HOLD_SEL_W-1:0] holdSelect,
	output logic                       flag
);
	logic [HOLD_CNT_W-1:0] holdCnt_q;
	logic [HOLD_CNT_W-1:0] holdCnt_d;
	logic                  flag_q;
	logic                  flag_d;
	logic                  hit;

	// ==========================================
	// Compare and hold
	// Counter reloads on every hit so the flag stretches past the last event
	always_comb begin
		hit       = detectEnable && (ortm_mag(sample) >= threshold);
		holdCnt_d = holdCnt_q;
		if (hit) begin
			holdCnt_d = ortm_hold_len(holdSelect);
		end else if (holdCnt_q != HOLD_CNT_RESET) begin
			holdCnt_d = holdCnt_q - 11'h001;
		end
		flag_d = (holdCnt_d != HOLD_CNT_RESET);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdCnt_q <= HOLD_CNT_RESET;
			flag_q    <= 1'b0;
		end else begin
			holdCnt_q <= holdCnt_d;
			flag_q    <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule // ortm_hold_chan

// ===== core/ortm_top.sv
// Over-range flags for four channels plus trigger marker retiming,
// trigger repeat and marker insertion into link sample words.
// Assumes samples come from the converter cores on core_clk (sample clock);
// marker_input is asynchronous and is synchronised here.
`timescale 1ns/1ps

module ortm_top
	import ortm_pkg::*;
#(
	parameter int NUM_CHANNELS = 4
)(
	input  wire logic                            core_clk,
	input  wire logic                            rst,
	input  wire logic [ortm_pkg::SAMPLE_W-1:0]   sample_a,
	input  wire logic [ortm_pkg::SAMPLE_W-1:0]   sample_b,
	input  wire logic [ortm_pkg::SAMPLE_W-1:0]   sample_c,
	input  wire logic [ortm_pkg::SAMPLE_W-1:0]   sample_d,
	input  wire logic                            overrange_detect_enable,
	input  wire logic [ortm_pkg::MAG_W-1:0]      overrange_threshold,
	input  wire logic [ortm_pkg::HOLD_SEL_W-1:0] overrange_hold_select,
	input  wire logic                            marker_input,
	input  wire logic                            marker_receiver_enable,
	input  wire logic                            trigger_repeat_enable,
	input  wire logic [ortm_pkg::TRIG_SEL_W-1:0] trigger_repeat_select,
	input  wire logic                            marker_insert_enable,
	input  wire logic [ortm_pkg::LMODE_W-1:0]    link_mode_select,
	output logic                                 overrange_out_a,
	output logic                                 overrange_out_b,
	output logic                                 overrange_out_c,
	output logic                                 overrange_out_d,
	output logic                                 trigger_repeat_out,
	output logic [ortm_pkg::LINK_W-1:0]          link_word_a,
	output logic [ortm_pkg::LINK_W-1:0]          link_word_b,
	output logic [ortm_pkg::LINK_W-1:0]          link_word_c,
	output logic [ortm_pkg::LINK_W-1:0]          link_word_d,
	output logic [ortm_pkg::LINK_W-1:0]          link_sample_width
);
	import ortm_pkg::*;

	// ==========================================
	// Sample capture
	// Converter results are taken on the rising sample clock edge
	logic [SAMPLE_W-1:0] smp_q [NUM_CH];
	logic [SAMPLE_W-1:0] smp_d [NUM_CH];
	logic [SAMPLE_W-1:0] smp2_q [NUM_CH];
	logic [SAMPLE_W-1:0] smp2_d [NUM_CH];

	always_comb begin
		smp_d[0] = sample_a;
		smp_d[1] = sample_b;
		smp_d[2] = sample_c;
		smp_d[3] = sample_d;
		for (int i = 0; i < NUM_CH; i++) begin
			smp2_d[i] = smp_q[i];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				smp_q[i]  <= '0;
				smp2_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				smp_q[i]  <= smp_d[i];
				smp2_q[i] <= smp2_d[i];
			end
		end
	end

	// ==========================================
	// Over-range detection per channel
	logic chanFlag [NUM_CH];

	for (genvar g = 0; g < NUM_CH; g++) begin : gChan
		ortm_hold_chan uChan (
			.core_clk     (core_clk),
			.rst          (rst),
			.detectEnable (overrange_detect_enable && (g < NUM_CHANNELS)),
			.sample       (smp_q[g]),
			.threshold    (overrange_threshold),
			.holdSelect   (overrange_hold_select),
			.flag         (chanFlag[g])
		);
	end

	// Flags come straight from the channel flops
	assign overrange_out_a = chanFlag[0];
	assign overrange_out_b = chanFlag[1];
	assign overrange_out_c = chanFlag[2];
	assign overrange_out_d = chanFlag[3];

	// ==========================================
	// Marker synchroniser
	// Three stages; a change counts only once stages two and three agree,
	// which filters a single metastable resolution glitch
	logic [SYNC_STAGES-1:0] mkSync_q;
	logic [SYNC_STAGES-1:0] mkSync_d;
	logic                   mkStable_q;
	logic                   mkStable_d;

	always_comb begin
		mkSync_d   = {mkSync_q[SYNC_STAGES-2:0], marker_input};
		mkStable_d = mkStable_q;
		if (mkSync_q[1] == mkSync_q[2]) begin
			mkStable_d = mkSync_q[1] && marker_receiver_enable;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mkSync_q   <= '0;
			mkStable_q <= 1'b0;
		end else begin
			mkSync_q   <= mkSync_d;
			mkStable_q <= mkStable_d;
		end
	end

	// ==========================================
	// Marker alignment with samples
	// Delay line equalises marker and sample paths; the synchroniser's own
	// latency cannot be removed, so the mark trails the analog instant
	// by that fixed amount
	logic [SAMPLE_LATENCY-1:0] mkDly_q;
	logic [SAMPLE_LATENCY-1:0] mkDly_d;

	always_comb begin
		mkDly_d = {mkDly_q[SAMPLE_LATENCY-2:0], mkStable_q};
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mkDly_q <= '0;
		end else begin
			mkDly_q <= mkDly_d;
		end
	end

	// ==========================================
	// Trigger repeat
	logic trigger_repeat_out_q;
	logic trigger_repeat_out_d;

	always_comb begin
		trigger_repeat_out_d = 1'b0;
		if (marker_receiver_enable && trigger_repeat_enable
			&& (trigger_repeat_select == TRIG_SEL_REPEAT)) begin
			trigger_repeat_out_d = mkStable_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trigger_repeat_out_q <= 1'b0;
		end else begin
			trigger_repeat_out_q <= trigger_repeat_out_d;
		end
	end

	assign trigger_repeat_out = trigger_repeat_out_q;

	// ==========================================
	// Link word formatting
	// Sample left-justified in the word; marker or zero in bit 0
	logic [LINK_W-1:0] lw_q [NUM_CH];
	logic [LINK_W-1:0] lw_d [NUM_CH];
	logic [LINK_W-1:0] lwidth_q;
	logic [LINK_W-1:0] lwidth_d;
	logic              mkIns;

	always_comb begin
		mkIns = marker_insert_enable && marker_receiver_enable && mkDly_q[SAMPLE_LATENCY-1];
		for (int i = 0; i < NUM_CH; i++) begin
			lw_d[i]                 = {smp2_q[i], 3'h0};
			lw_d[i][MARKER_BIT_POS] = mkIns;
		end
		lwidth_d = LINK_W'(LINK_MODE0_WIDTH);
		if (link_mode_select != LINK_MODE_0) begin
			lwidth_d = LINK_W'(LINK_W);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				lw_q[i] <= '0;
			end
			lwidth_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				lw_q[i] <= lw_d[i];
			end
			lwidth_q <= lwidth_d;
		end
	end

	assign link_word_a       = lw_q[0];
	assign link_word_b       = lw_q[1];
	assign link_word_c       = lw_q[2];
	assign link_word_d       = lw_q[3];
	assign link_sample_width = lwidth_q;
endmodule // ortm_top

// ===== sim/ortm_checker.sv
// Checker: flag hold, link word, trigger and width relations.
// Bound into ortm_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module ortm_checker (
	input wire logic                            core_clk, rst, overrange_detect_enable,
	input wire logic [ortm_pkg::SAMPLE_W-1:0]   sample_a, sample_b, sample_c, sample_d,
	input wire logic [ortm_pkg::MAG_W-1:0]      overrange_threshold,
	input wire logic [ortm_pkg::HOLD_SEL_W-1:0] overrange_hold_select,
	input wire logic                            marker_input, marker_receiver_enable, trigger_repeat_enable,
	input wire logic [ortm_pkg::TRIG_SEL_W-1:0] trigger_repeat_select,
	input wire logic [ortm_pkg::LMODE_W-1:0]    link_mode_select,
	input wire logic                            marker_insert_enable, trigger_repeat_out,
	input wire logic                            overrange_out_a, overrange_out_b, overrange_out_c, overrange_out_d,
	input wire logic [ortm_pkg::LINK_W-1:0]     link_word_a, link_sample_width
);
	import ortm_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [ortm_pkg::SAMPLE_W-1:0] sR_q [4];
	logic [3:0]  hitNow;
	logic [10:0] age_d [4], age_q [4];
	int          holdLen;
	// ==========================================
	// Helper: cycles since each channel's last hit
	function automatic logic isHit(input logic signed [SAMPLE_W-1:0] s);
		int a;
		a = s;
		if (a < 0) a = -a;
		if (a > 255) a = 255; // Saturates, -256 reads as full scale
		return overrange_detect_enable && a >= overrange_threshold;
	endfunction
	assign holdLen = 8 << overrange_hold_select;
	always_comb begin
		// Captured sample meets the enable and threshold of the following edge
		hitNow = {isHit(sR_q[3]), isHit(sR_q[2]), isHit(sR_q[1]), isHit(sR_q[0])};
		for (int i = 0; i < 4; i++) begin
			age_d[i] = hitNow[i] ? 11'h000 : (age_q[i] == 11'h7ff ? age_q[i] : age_q[i] + 11'h001);
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sR_q   <= '{default: 9'h000};
			age_q  <= '{default: 11'h7ff};
		end else begin
			sR_q   <= '{sample_a, sample_b, sample_c, sample_d};
			age_q  <= age_d;
		end
	end
	// ==========================================
	// Assertions
	a_hold_chan_a: assert property (overrange_out_a == (age_q[0] < holdLen))
		else $error("flag a hold length wrong");
	a_hold_chan_b: assert property (overrange_out_b == (age_q[1] < holdLen))
		else $error("flag b hold length wrong");
	a_hold_chan_c: assert property (overrange_out_c == (age_q[2] < holdLen))
		else $error("flag c hold length wrong");
	a_hold_chan_d: assert property (overrange_out_d == (age_q[3] < holdLen))
		else $error("flag d hold length wrong");
	a_link_data: assert property (link_word_a[11:1] == {$past(sample_a, 3), 2'h0})
		else $error("link word sample field wrong");
	a_link_marker: assert property (link_word_a[0] == ($past(marker_input, 7) && marker_receiver_enable && marker_insert_enable))
		else $error("link marker bit wrong");
	a_trig_repeat: assert property (trigger_repeat_out == ($past(marker_input, 5) && marker_receiver_enable
		&& trigger_repeat_enable && trigger_repeat_select == 2'h3))
		else $error("trigger repeat wrong");
	a_width_mode0: assert property ((link_mode_select == 4'h0 && !$past(rst)) |-> link_sample_width == 12'h00c)
		else $error("link sample width wrong");
endmodule // ortm_checker
bind ortm_top ortm_checker ortm_checker_i (.*);

// ===== sim/ortm_gain_model.sv
// Downstream gain-control model: backs off on a flag, restores later.
// Watches the channel a flag and link word on core_clk.
`timescale 1ns/1ps
module ortm_gain_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        flag,
	input  wire logic [11:0] linkWord,
	output logic             gainLow
);
	int quiet;
	// Flag only starts the back-off; own sample watch ends it
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gainLow <= 1'b0;
			quiet   <= 0;
		end else if (flag) begin
			gainLow <= 1'b1;
			quiet   <= 0;
		end else if (gainLow) begin
			quiet <= (linkWord[11:10] == 2'b00 || linkWord[11:10] == 2'b11) ? quiet + 1 : 0;
			if (quiet == 15) gainLow <= 1'b0;
		end
	end
endmodule // ortm_gain_model

// ===== sim/tb_ortm_top.sv
// Testbench: random samples and marker pulses against a queue model.
// Drives inputs and compares outputs at the falling edge of core_clk.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_ortm_top;
	import ortm_pkg::*;
	logic        core_clk = 0, rst = 1, en = 0, mk = 0, rx = 0, rep = 0, ins = 0, go = 0;
	logic [8:0]  smp [4] = '{default: 9'h000};
	logic [8:0]  bnd [5] = '{9'h100, 9'h0ff, 9'h102, 9'h0fe, 9'h000};
	logic [7:0]  thr = 8'he4;
	logic [2:0]  hsel = 3'h0;
	logic [1:0]  tsel = 2'h0;
	wire  [3:0]  fl;
	wire  [11:0] wd [4];
	wire  [11:0] width;
	wire         trig, gainLow;
	int          num_errors = 0, tests_run = 0, seed = 19396, cnt [4], r;
	logic        hp [4], mq [$];
	logic [8:0]  sq [4][$];
	initial forever #2.5 core_clk = ~core_clk;
	ortm_top ortm_top_i (
		.core_clk(core_clk), .rst(rst), .sample_a(smp[0]), .sample_b(smp[1]), .sample_c(smp[2]),
		.sample_d(smp[3]), .overrange_detect_enable(en), .overrange_threshold(thr),
		.overrange_hold_select(hsel), .marker_input(mk), .marker_receiver_enable(rx),
		.trigger_repeat_enable(rep), .trigger_repeat_select(tsel), .marker_insert_enable(ins),
		.link_mode_select(4'h0), .overrange_out_a(fl[0]), .overrange_out_b(fl[1]),
		.overrange_out_c(fl[2]), .overrange_out_d(fl[3]), .trigger_repeat_out(trig),
		.link_word_a(wd[0]), .link_word_b(wd[1]), .link_word_c(wd[2]), .link_word_d(wd[3]),
		.link_sample_width(width)
	);
	ortm_gain_model ortm_gain_model_i (
		.core_clk(core_clk), .rst(rst), .flag(fl[0]), .linkWord(wd[0]), .gainLow(gainLow)
	);
	// ==========================================
	// Reference model, stepped on each rising edge
	function automatic int mag(input logic signed [8:0] s);
		int a;
		a = s;
		if (a < 0) a = -a;
		return (a > 255) ? 255 : a;
	endfunction
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mq = '{0, 0, 0, 0, 0, 0, 0};
			foreach (cnt[i]) begin
				cnt[i] = 0;
				hp[i] = 0;
				sq[i] = '{9'h000, 9'h000, 9'h000};
			end
		end else begin
			foreach (cnt[i]) begin
				hp[i] = en && mag(sq[i][0]) >= thr;
				cnt[i] = hp[i] ? (8 << hsel) : (cnt[i] > 0 ? cnt[i] - 1 : 0);
				sq[i].push_front(smp[i]);
				void'(sq[i].pop_back());
			end
			mq.push_front(mk);
			void'(mq.pop_back());
		end
	end
	// Outputs are settled by the falling edge
	always @(negedge core_clk) begin
		if (go) begin
			foreach (cnt[i]) begin
				`CHK(fl[i], cnt[i] > 0)
				`CHK(wd[i], {sq[i][2], 2'h0, mq[6] & rx & ins})
			end
			`CHK(trig, mq[4] & rx & rep & (tsel == 2'h3))
			`CHK(width, 12'h00c)
		end
	end
	// ==========================================
	// Stimulus
	task automatic drive(input int n, input bit rnd);
		repeat (n) begin
			@(negedge core_clk);
			foreach (smp[i]) begin
				r = $random(seed);
				smp[i] = !rnd ? 9'h000 : (r[31:29] == 3'h0) ? bnd[r[2:0] % 5] : r[8:0];
			end
		end
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] thrTab [8];
		thrTab = '{8'he4, 8'hff, 8'h00, 8'hfe, 8'h01, 8'hc8, 8'h80, 8'he4};
		repeat (16) @(posedge core_clk);
		@(negedge core_clk) rst = 0;
		@(negedge core_clk) go = 1;
		// Every hold code; longest hold drains before the next code
		for (int s = 0; s < 8; s++) begin
			@(negedge core_clk);
			hsel = s;
			thr = thrTab[s];
			en = 1;
			drive(200, 1);
			en = 0;
			drive(1030, 0);
		end
		drive(100, 1);
		en = 1;
		// Marker under every enable combination, changed while random samples run
		for (int c = 0; c < 32; c++) begin
			{ins, tsel, rep, rx} = c[4:0];
			repeat (3) begin
				mk = 1;
				drive(3 + ($random(seed) & 3), 1);
				mk = 0;
				drive(10, 1);
			end
		end
		tally_and_finish();
	end
endmodule // tb_ortm_top
